// File: design/bps_params.svh
`ifndef BPS_PARAMS_SVH
`define BPS_PARAMS_SVH

// Clock period of MCLK in nanoseconds.
`define BPS_CLK_PERIOD_NS   100
// Bus voltage filter time and crystal start delay, in nanoseconds.
`define BPS_BUS_FILTER_NS   2000000
`define BPS_OSC_DELAY_NS    2000000

// Register offsets of the plain register port.
`define BPS_ADDR_CTRL       4'h0
`define BPS_ADDR_STATUS     4'h4

// Control register fields and reset values.
`define BPS_CTRL_ADJ_EN     0
`define BPS_CTRL_AUX_EN     1
`define BPS_CTRL_DOUBLER    2
`define BPS_CTRL_CLK_EN     3
`define BPS_CTRL_SLEEP      4
`define BPS_CTRL_RESET      4'hB

// Status register fields.
`define BPS_ST_BUS          0
`define BPS_ST_FILT         1
`define BPS_ST_ADJ          2
`define BPS_ST_AUX          3
`define BPS_ST_OSC          4
`define BPS_ST_TW           5
`define BPS_ST_TSD          6
`define BPS_ST_CMODE        7
`define BPS_ST_STATE_LO     8

`endif

// File: design/bps_pkg.sv
package bps_pkg;

    // Power states of the sequencer.
    typedef enum logic [2:0] {
        BPS_RESET   = 3'h0,
        BPS_STARTUP = 3'h1,
        BPS_STANDBY = 3'h2,
        BPS_NORMAL  = 3'h3,
        BPS_SLEEP   = 3'h4
    } bps_state_t;

    // Host clock output selection.
    typedef enum logic [1:0] {
        BPS_CLK_OFF = 2'h0,
        BPS_CLK_4M  = 2'h1,
        BPS_CLK_8M  = 2'h2,
        BPS_CLK_16M = 2'h3
    } bps_clk_sel_t;

endpackage

// File: design/bps_sequencer.sv
// Summary of operation
// - Fixed buck turns on automatically at power-up.
// - Adjustable buck needs filtered-supply-good and enable.
// - Adjustable buck output good is readable status.
// - Aux regulator enabled by default, host disables.
// - Aux regulator off until filtered-supply-good.
// - Aux regulator good is readable status.
// - Normal clock 8 MHz, doubler 16, enable stops.
// - Stand-by from start-up outputs internal 4 MHz.
// - Normal entry switches to crystal 8/16 MHz.
// - Normal to stand-by keeps clock unless crystal fault.
// - Wake pin level selects bus current mode.
// - Low wake pin in sleep starts power-up.
// - No wake when pin permanently grounded.
// - Filtered supply below 14 V: warning at once.
// - Bus below 20 V for 2 ms: warning.
// - Filtered supply below 12 V asserts host reset.
// - Thermal shutdown holds host reset low.
// - Reset and warning are open-drain active low.
// - Serial, bus, oscillator activity follow power state.
// - Comparator results readable as status flags, except 14 V, 12 V, start and fixed good.
// - Normal only with oscillator, no thermal, supplies good.
// - Crystal starts about 2 ms after stand-by entry.
// - Bus flag clearing leaves normal, warning low.
// - Adjustable buck and aux each need their enable bit.
`timescale 1ns/1ns
`include "bps_params.svh"

module bps_sequencer #(
    parameter int BUS_FILTER_CYCLES = `BPS_BUS_FILTER_NS / `BPS_CLK_PERIOD_NS,
    parameter int OSC_DELAY_CYCLES  =
        (`BPS_OSC_DELAY_NS + `BPS_CLK_PERIOD_NS - 1) / `BPS_CLK_PERIOD_NS
) (
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic        BUS_ABOVE_CMP,
    input  wire logic        FILT_GOOD_CMP,
    input  wire logic        FILT_14V_CMP,
    input  wire logic        FILT_12V_CMP,
    input  wire logic        FILT_START_CMP,
    input  wire logic        FIXED_GOOD_CMP,
    input  wire logic        ADJ_GOOD_CMP,
    input  wire logic        AUX_GOOD_CMP,
    input  wire logic        OSC_RUNNING,
    input  wire logic        THERMAL_WARN,
    input  wire logic        THERMAL_SHUTDOWN,
    input  wire logic        CURRENT_MODE_WAKE_PIN,
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [15:0] REG_RDATA,
    output logic             FIXED_BUCK_EN,
    output logic             ADJ_BUCK_EN,
    output logic             AUX_REG_EN,
    output logic             OSC_EN,
    output logic       [1:0] HOST_CLOCK_SEL,
    output logic             CURRENT_MODE_HIGH,
    output logic             SERIAL_ACTIVE,
    output logic             BUS_COMM_ACTIVE,
    output logic             EARLY_WARNING_N_O,
    output logic             EARLY_WARNING_N_OE,
    output logic             HOST_RESET_N_O,
    output logic             HOST_RESET_N_OE,
    output logic       [2:0] POWER_STATE
);

    localparam int NSYNC = 12;

    // Raw asynchronous inputs gathered so one generate loop synchronises them.
    logic [NSYNC-1:0] raw_in;
    // Three-stage synchroniser chain per input.
    logic [NSYNC-1:0] s1_r;
    logic [NSYNC-1:0] s2_r;
    logic [NSYNC-1:0] s3_r;
    // Accepted level once stages two and three agree.
    logic [NSYNC-1:0] in_r;

    // Power state and its next value.
    bps_pkg::bps_state_t state_r;
    bps_pkg::bps_state_t state_nxt;

    // Control register and bus flag filter.
    logic [4:0]  ctrl_r;
    logic        bus_flag_r;
    logic [31:0] bus_cnt_r;
    // Crystal start delay counter and done marker.
    logic [31:0] osc_cnt_r;
    logic        osc_go_r;
    // Stand-by was entered from normal; crystal fault caused it.
    logic        from_normal_r;
    logic        xtal_fault_r;
    // Wake pin has been seen high while asleep.
    logic        wake_armed_r;

    assign raw_in = {CURRENT_MODE_WAKE_PIN, THERMAL_SHUTDOWN, THERMAL_WARN, OSC_RUNNING,
                     AUX_GOOD_CMP, ADJ_GOOD_CMP, FIXED_GOOD_CMP, FILT_START_CMP,
                     FILT_12V_CMP, FILT_14V_CMP, FILT_GOOD_CMP, BUS_ABOVE_CMP};

    // Named views of the accepted inputs.
    wire bus_ok   = in_r[0];
    wire filt_ok  = in_r[1];
    wire f14_ok   = in_r[2];
    wire f12_ok   = in_r[3];
    wire f_start  = in_r[4];
    wire fix_ok   = in_r[5];
    wire adj_ok   = in_r[6];
    wire aux_ok   = in_r[7];
    wire osc_ok   = in_r[8];
    wire tw       = in_r[9];
    wire thermal_shutdown_flag      = in_r[10];
    wire wake_pin = in_r[11];

    // Each outside level passes three flops; the first feeds only the second.
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge MCLK or posedge RST) begin
                if (RST) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                    in_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= raw_in[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    // A change only counts when two stages agree.
                    if (s2_r[gi] == s3_r[gi]) begin
                        in_r[gi] <= s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // True in the states where supplies and host interface are up.
    function automatic logic is_up(input bps_pkg::bps_state_t s);
        is_up = (s == bps_pkg::BPS_STANDBY) || (s == bps_pkg::BPS_NORMAL);
    endfunction

    // Conditions that allow the normal state.
    wire normal_ok = osc_ok && !tw && !thermal_shutdown_flag && bus_flag_r && filt_ok && adj_ok && aux_ok;
    // A sleep request is honoured only while the wake pin is high.
    wire sleep_req = REG_WR && (REG_ADDR == `BPS_ADDR_CTRL) &&
                     REG_WDATA[`BPS_CTRL_SLEEP] && wake_pin;

    // Bus voltage flag: set at once, cleared only after the low level lasts the filter time.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            bus_flag_r <= 1'b0;
            bus_cnt_r  <= 32'h0;
        end else if (bus_ok) begin
            bus_flag_r <= 1'b1;
            bus_cnt_r  <= 32'h0;
        end else if (bus_cnt_r >= 32'(BUS_FILTER_CYCLES - 1)) begin
            bus_flag_r <= 1'b0;
        end else begin
            bus_cnt_r <= bus_cnt_r + 32'h1;
        end
    end

    // Next power state.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            bps_pkg::BPS_RESET: begin
                if (f_start && !thermal_shutdown_flag) begin
                    state_nxt = bps_pkg::BPS_STARTUP;
                end
            end
            bps_pkg::BPS_STARTUP: begin
                if (thermal_shutdown_flag || !f_start) begin
                    state_nxt = bps_pkg::BPS_RESET;
                end else if (fix_ok) begin
                    state_nxt = bps_pkg::BPS_STANDBY;
                end
            end
            bps_pkg::BPS_STANDBY: begin
                if (thermal_shutdown_flag || !fix_ok) begin
                    state_nxt = bps_pkg::BPS_RESET;
                end else if (sleep_req) begin
                    state_nxt = bps_pkg::BPS_SLEEP;
                end else if (normal_ok && osc_go_r) begin
                    state_nxt = bps_pkg::BPS_NORMAL;
                end
            end
            bps_pkg::BPS_NORMAL: begin
                if (thermal_shutdown_flag || !fix_ok) begin
                    state_nxt = bps_pkg::BPS_RESET;
                end else if (sleep_req) begin
                    state_nxt = bps_pkg::BPS_SLEEP;
                end else if (!normal_ok) begin
                    state_nxt = bps_pkg::BPS_STANDBY;
                end
            end
            bps_pkg::BPS_SLEEP: begin
                if (wake_armed_r && !wake_pin) begin
                    state_nxt = bps_pkg::BPS_STARTUP;
                end
            end
            default: begin
                // An illegal code falls back to reset.
                state_nxt = bps_pkg::BPS_RESET;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_r <= bps_pkg::BPS_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Record how stand-by was entered so the clock source can be chosen.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            from_normal_r <= 1'b0;
            xtal_fault_r  <= 1'b0;
        end else if (state_r == bps_pkg::BPS_NORMAL &&
                     state_nxt == bps_pkg::BPS_STANDBY) begin
            from_normal_r <= 1'b1;
            xtal_fault_r  <= !osc_ok;
        end else if (!is_up(state_r)) begin
            from_normal_r <= 1'b0;
            xtal_fault_r  <= 1'b0;
        end
    end

    // Sleep wake arming: a pin tied to ground never shows high, so never arms.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            wake_armed_r <= 1'b0;
        end else if (state_r == bps_pkg::BPS_SLEEP) begin
            if (wake_pin) begin
                wake_armed_r <= 1'b1;
            end
        end else begin
            wake_armed_r <= 1'b0;
        end
    end

    // Crystal start delay, counted from stand-by entry out of start-up.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            osc_cnt_r <= 32'h0;
            osc_go_r  <= 1'b0;
        end else if (!is_up(state_r)) begin
            osc_cnt_r <= 32'h0;
            osc_go_r  <= 1'b0;
        end else if (osc_cnt_r >= 32'(OSC_DELAY_CYCLES - 1)) begin
            osc_go_r <= 1'b1;
        end else begin
            osc_cnt_r <= osc_cnt_r + 32'h1;
        end
    end

    // Control register; the sleep field is a command and is not stored.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ctrl_r <= {1'b0, `BPS_CTRL_RESET};
        end else if (REG_WR && REG_ADDR == `BPS_ADDR_CTRL) begin
            ctrl_r <= {1'b0, REG_WDATA[`BPS_CTRL_CLK_EN:`BPS_CTRL_ADJ_EN]};
        end
    end

    // Read data stand one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 16'h0;
        end else if (REG_RD && REG_ADDR == `BPS_ADDR_CTRL) begin
            REG_RDATA <= {11'h0, ctrl_r};
        end else if (REG_RD && REG_ADDR == `BPS_ADDR_STATUS) begin
            REG_RDATA <= 16'h0;
            REG_RDATA[`BPS_ST_BUS]  <= bus_flag_r;
            REG_RDATA[`BPS_ST_FILT] <= filt_ok;
            REG_RDATA[`BPS_ST_ADJ]  <= adj_ok;
            REG_RDATA[`BPS_ST_AUX]  <= aux_ok;
            REG_RDATA[`BPS_ST_OSC]  <= osc_ok;
            REG_RDATA[`BPS_ST_TW]   <= tw;
            REG_RDATA[`BPS_ST_TSD]  <= thermal_shutdown_flag;
            REG_RDATA[`BPS_ST_CMODE] <= CURRENT_MODE_HIGH;
            REG_RDATA[`BPS_ST_STATE_LO +: 3] <= state_r;
        end else begin
            REG_RDATA <= 16'h0;
        end
    end

    // Converter enables; sampled from the next state so they track it.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            FIXED_BUCK_EN <= 1'b0;
            ADJ_BUCK_EN   <= 1'b0;
            AUX_REG_EN    <= 1'b0;
        end else begin
            FIXED_BUCK_EN <= state_nxt != bps_pkg::BPS_RESET &&
                             state_nxt != bps_pkg::BPS_SLEEP;
            ADJ_BUCK_EN   <= is_up(state_nxt) && filt_ok && ctrl_r[`BPS_CTRL_ADJ_EN];
            AUX_REG_EN    <= is_up(state_nxt) && filt_ok && ctrl_r[`BPS_CTRL_AUX_EN];
        end
    end

    // Oscillator and host clock selection by power state.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            OSC_EN         <= 1'b0;
            HOST_CLOCK_SEL <= bps_pkg::BPS_CLK_OFF;
        end else begin
            OSC_EN <= is_up(state_r) && osc_go_r;
            if (!is_up(state_r) || !ctrl_r[`BPS_CTRL_CLK_EN]) begin
                HOST_CLOCK_SEL <= bps_pkg::BPS_CLK_OFF;
            end else if (state_r == bps_pkg::BPS_STANDBY &&
                         (!from_normal_r || xtal_fault_r)) begin
                HOST_CLOCK_SEL <= bps_pkg::BPS_CLK_4M;
            end else if (ctrl_r[`BPS_CTRL_DOUBLER]) begin
                HOST_CLOCK_SEL <= bps_pkg::BPS_CLK_16M;
            end else begin
                HOST_CLOCK_SEL <= bps_pkg::BPS_CLK_8M;
            end
        end
    end

    // Mode tracks the pin in reset only; a wake press skips reset and cannot flip it.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            CURRENT_MODE_HIGH <= 1'b0;
        end else if (state_r == bps_pkg::BPS_RESET) begin
            CURRENT_MODE_HIGH <= !wake_pin;
        end
    end

    // Activity flags and open-drain supervisor outputs.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            SERIAL_ACTIVE      <= 1'b0;
            BUS_COMM_ACTIVE    <= 1'b0;
            EARLY_WARNING_N_O  <= 1'b0;
            EARLY_WARNING_N_OE <= 1'b1;
            HOST_RESET_N_O     <= 1'b0;
            HOST_RESET_N_OE    <= 1'b1;
            POWER_STATE        <= 3'h0;
        end else begin
            SERIAL_ACTIVE     <= is_up(state_r);
            BUS_COMM_ACTIVE   <= state_r == bps_pkg::BPS_NORMAL;
            EARLY_WARNING_N_O <= 1'b0;
            HOST_RESET_N_O    <= 1'b0;
            EARLY_WARNING_N_OE <= !(state_r == bps_pkg::BPS_NORMAL && f14_ok && bus_flag_r);
            HOST_RESET_N_OE   <= !(is_up(state_r) && f12_ok && !thermal_shutdown_flag);
            POWER_STATE       <= state_r;
        end
    end

endmodule

// File: tb/bps_host_model.sv
`timescale 1ns/1ns
// Host side: sees the open-drain pins through their pull-ups and works the wake button.
module bps_host_model (
    input  wire logic rst_o,
    input  wire logic rst_oe,
    input  wire logic warn_o,
    input  wire logic warn_oe,
    input  wire logic press,
    input  wire logic tie_low,
    output logic      reset_n,
    output logic      warn_n,
    output logic      comm_ok,
    output logic      wake_pin
);
    assign reset_n = rst_oe ? rst_o : 1'b1;
    assign warn_n = warn_oe ? warn_o : 1'b1;
    assign comm_ok = reset_n;
    assign wake_pin = (press || tie_low) ? 1'b0 : 1'b1;
endmodule

// File: tb/bps_sequencer_props.sv
`timescale 1ns/1ns
// Ties every power-state output except host reset to the state it must follow; host reset follows 12 V and thermal.
module bps_sequencer_props #(
    parameter int BUS_FILTER_CYCLES = 8
) (
    input wire logic       MCLK,
    input wire logic       RST,
    input wire logic       BUS_ABOVE_CMP,
    input wire logic       FILT_14V_CMP,
    input wire logic       FILT_12V_CMP,
    input wire logic       THERMAL_SHUTDOWN,
    input wire logic       FIXED_BUCK_EN,
    input wire logic       ADJ_BUCK_EN,
    input wire logic       AUX_REG_EN,
    input wire logic       OSC_EN,
    input wire logic [1:0] HOST_CLOCK_SEL,
    input wire logic       SERIAL_ACTIVE,
    input wire logic       BUS_COMM_ACTIVE,
    input wire logic       EARLY_WARNING_N_O,
    input wire logic       EARLY_WARNING_N_OE,
    input wire logic       HOST_RESET_N_O,
    input wire logic       HOST_RESET_N_OE,
    input wire logic [2:0] POWER_STATE
);
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (RST);
    // Cycles of low bus in a row; saturates so a long outage cannot wrap.
    logic [15:0] low_cnt_r;
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            low_cnt_r <= 16'h0000;
        end else if (BUS_ABOVE_CMP) begin
            low_cnt_r <= 16'h0000;
        end else if (low_cnt_r != 16'hFFFF) begin
            low_cnt_r <= low_cnt_r + 16'h0001;
        end
    end
    bus_filt_a: assert property (
        POWER_STATE == 3'h3 |-> low_cnt_r <= BUS_FILTER_CYCLES + 8)
        else $error("normal held after bus loss");
    // Activity flags, clock select and the reported state are registered together.
    serial_state_a: assert property (
        1'b1 |-> SERIAL_ACTIVE == (POWER_STATE inside {3'h2, 3'h3}))
        else $error("serial activity wrong for state");
    bus_comm_a: assert property (
        1'b1 |-> BUS_COMM_ACTIVE == (POWER_STATE == 3'h3))
        else $error("bus activity wrong for state");
    clk_off_a: assert property (
        POWER_STATE inside {3'h0, 3'h1, 3'h4} |-> HOST_CLOCK_SEL == 2'h0)
        else $error("clock output running while down");
    osc_off_a: assert property (
        POWER_STATE inside {3'h0, 3'h1, 3'h4} |-> !OSC_EN)
        else $error("oscillator enabled while down");
    // Enables follow the next state, so they lead the reported state by one cycle.
    fixed_on_a: assert property (
        POWER_STATE inside {3'h1, 3'h2, 3'h3} |-> $past(FIXED_BUCK_EN))
        else $error("fixed buck off while up");
    all_off_a: assert property (
        POWER_STATE inside {3'h0, 3'h4} |->
            !($past(FIXED_BUCK_EN) || $past(ADJ_BUCK_EN) || $past(AUX_REG_EN)))
        else $error("supply enabled in reset or sleep");
    od_low_a: assert property (
        HOST_RESET_N_O == 1'b0 && EARLY_WARNING_N_O == 1'b0)
        else $error("open-drain drives high");
    warn_state_a: assert property (
        POWER_STATE != 3'h3 |-> EARLY_WARNING_N_OE)
        else $error("warning released outside normal");
    fast_warn_a: assert property (
        !FILT_14V_CMP [*8] |-> EARLY_WARNING_N_OE)
        else $error("warning late on low filter");
    rst_low_a: assert property (
        !FILT_12V_CMP [*8] |-> HOST_RESET_N_OE)
        else $error("host reset late on low filter");
    tsd_hold_a: assert property (
        THERMAL_SHUTDOWN [*8] |-> HOST_RESET_N_OE)
        else $error("host reset released in shutdown");
    cover property (POWER_STATE == 3'h3);
    cover property (POWER_STATE == 3'h4);
    cover property (POWER_STATE == 3'h3 ##1 POWER_STATE == 3'h2);
endmodule

// File: tb/bus_powered_supervisor_sequencer_test.sv
`timescale 1ns/1ns
`include "bps_params.svh"
module bus_powered_supervisor_sequencer_test;
    localparam int FILT = 8;
    logic        mclk, rst, bus_ok, filt_ok, f14, f12, fstart, fix_ok;
    logic        adj_ok, aux_ok, osc_ok, tw, thermal_shutdown_flag, wr_s, rd_s, press, tie_low;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata;
    logic        fix_en, adj_en, aux_en, osc_en, cm_hi, ser, comm, wake;
    logic        warn_o, warn_oe, rst_o, rst_oe, rst_pin, warn_pin, comm_ok;
    logic [1:0]  sel;
    logic [2:0]  pst;
    int          bad_count, check_count, wcnt;

    bps_sequencer #(.BUS_FILTER_CYCLES(FILT), .OSC_DELAY_CYCLES(8)) dut (
        .MCLK(mclk), .RST(rst), .BUS_ABOVE_CMP(bus_ok), .FILT_GOOD_CMP(filt_ok),
        .FILT_14V_CMP(f14), .FILT_12V_CMP(f12), .FILT_START_CMP(fstart),
        .FIXED_GOOD_CMP(fix_ok), .ADJ_GOOD_CMP(adj_ok), .AUX_GOOD_CMP(aux_ok),
        .OSC_RUNNING(osc_ok), .THERMAL_WARN(tw), .THERMAL_SHUTDOWN(thermal_shutdown_flag),
        .CURRENT_MODE_WAKE_PIN(wake), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .FIXED_BUCK_EN(fix_en),
        .ADJ_BUCK_EN(adj_en), .AUX_REG_EN(aux_en), .OSC_EN(osc_en), .HOST_CLOCK_SEL(sel),
        .CURRENT_MODE_HIGH(cm_hi), .SERIAL_ACTIVE(ser), .BUS_COMM_ACTIVE(comm),
        .EARLY_WARNING_N_O(warn_o), .EARLY_WARNING_N_OE(warn_oe),
        .HOST_RESET_N_O(rst_o), .HOST_RESET_N_OE(rst_oe), .POWER_STATE(pst));

    bps_host_model host (.rst_o(rst_o), .rst_oe(rst_oe), .warn_o(warn_o),
        .warn_oe(warn_oe), .press(press), .tie_low(tie_low), .reset_n(rst_pin),
        .warn_n(warn_pin), .comm_ok(comm_ok), .wake_pin(wake));

    // Free-running 10 MHz main clock.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cb(input string nm, input logic e, input logic g);
        chk(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic cs(input bps_pkg::bps_clk_sel_t e);
        chk("clock_sel", 16'(e), 16'(sel));
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Waits a bounded time for a state; wcnt keeps the cycles it took.
    task automatic ws(input bps_pkg::bps_state_t s);
        wcnt = 0;
        while (pst !== s && wcnt < 400) begin
            cyc(1);
            wcnt++;
        end
        chk("state", 16'(s), 16'(pst));
        cyc(2);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
        @(posedge mclk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // A hang counts as a mismatch; the whole run needs a few hundred cycles.
    initial begin
        #(100 * 20000);
        bad_count++;
        wrap_up();
    end

    initial begin
        {bus_ok, filt_ok, f14, f12, fstart, fix_ok, adj_ok, aux_ok} = 8'h00;
        {osc_ok, tw, thermal_shutdown_flag, wr_s, rd_s, press} = 6'h00;
        tie_low = 1'b1;
        addr = 4'h0;
        wdata = 16'h0000;
        rst = 1'b1;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        cyc(1);
        cb("reset_pin", 1'b0, rst_pin);
        @(posedge mclk);
        {fstart, fix_ok, f12, f14} <= 4'hF;
        ws(bps_pkg::BPS_STANDBY);
        cs(bps_pkg::BPS_CLK_4M);
        cb("osc_en", 1'b0, osc_en);
        cb("serial", 1'b1, ser);
        cb("reset_pin", 1'b1, rst_pin);
        cb("aux_en", 1'b0, aux_en);
        cb("adj_en", 1'b0, adj_en);
        cb("cmode", 1'b1, cm_hi);
        rd(`BPS_ADDR_CTRL, 16'h000B, "ctrl");
        rd(4'h8, 16'h0000, "unmapped");
        @(posedge mclk);
        filt_ok <= 1'b1;
        cyc(8);
        cb("osc_en", 1'b1, osc_en);
        cb("aux_en", 1'b1, aux_en);
        cb("adj_en", 1'b1, adj_en);
        @(posedge mclk);
        {bus_ok, osc_ok, adj_ok, aux_ok} <= 4'hF;
        ws(bps_pkg::BPS_NORMAL);
        cs(bps_pkg::BPS_CLK_8M);
        cb("warn_pin", 1'b1, warn_pin);
        cb("bus_comm", 1'b1, comm);
        cb("comm_ok", 1'b1, comm_ok);
        rd(`BPS_ADDR_STATUS, 16'h039F, "status");
        wr(`BPS_ADDR_CTRL, 16'h001B);
        cyc(20);
        chk("state", 16'h0003, 16'(pst));
        rd(`BPS_ADDR_CTRL, 16'h000B, "ctrl");
        wr(`BPS_ADDR_CTRL, 16'h000F);
        cyc(3);
        cs(bps_pkg::BPS_CLK_16M);
        wr(`BPS_ADDR_CTRL, 16'h0003);
        cyc(3);
        cs(bps_pkg::BPS_CLK_OFF);
        wr(`BPS_ADDR_CTRL, 16'h000B);
        cyc(3);
        @(posedge mclk) f14 <= 1'b0;
        cyc(7);
        cb("warn_pin", 1'b0, warn_pin);
        @(posedge mclk) f14 <= 1'b1;
        cyc(7);
        @(posedge mclk) bus_ok <= 1'b0;
        cyc(5);
        @(posedge mclk) bus_ok <= 1'b1;
        repeat (14) begin
            cyc(1);
            cb("warn_hold", 1'b1, warn_pin);
        end
        @(posedge mclk) bus_ok <= 1'b0;
        ws(bps_pkg::BPS_STANDBY);
        cb("filter_wait", 1'b1, wcnt >= FILT);
        cb("warn_pin", 1'b0, warn_pin);
        cs(bps_pkg::BPS_CLK_8M);
        @(posedge mclk) bus_ok <= 1'b1;
        ws(bps_pkg::BPS_NORMAL);
        @(posedge mclk) osc_ok <= 1'b0;
        ws(bps_pkg::BPS_STANDBY);
        cs(bps_pkg::BPS_CLK_4M);
        @(posedge mclk) osc_ok <= 1'b1;
        ws(bps_pkg::BPS_NORMAL);
        wr(`BPS_ADDR_CTRL, 16'h0009);
        cyc(3);
        cb("aux_en", 1'b0, aux_en);
        wr(`BPS_ADDR_CTRL, 16'h000B);
        cyc(3);
        @(posedge mclk) f12 <= 1'b0;
        cyc(8);
        cb("reset_pin", 1'b0, rst_pin);
        @(posedge mclk) f12 <= 1'b1;
        tw <= 1'b1;
        ws(bps_pkg::BPS_STANDBY);
        @(posedge mclk) {tw, tie_low, thermal_shutdown_flag} <= 3'h1;
        cyc(8);
        cb("reset_pin", 1'b0, rst_pin);
        cb("comm_ok", 1'b0, comm_ok);
        @(posedge mclk) thermal_shutdown_flag <= 1'b0;
        ws(bps_pkg::BPS_NORMAL);
        cb("cmode", 1'b0, cm_hi);
        wr(`BPS_ADDR_CTRL, 16'h001B);
        ws(bps_pkg::BPS_SLEEP);
        cs(bps_pkg::BPS_CLK_OFF);
        cb("osc_en", 1'b0, osc_en);
        cb("serial", 1'b0, ser);
        @(posedge mclk) press <= 1'b1;
        cyc(6);
        @(posedge mclk) press <= 1'b0;
        ws(bps_pkg::BPS_STANDBY);
        cs(bps_pkg::BPS_CLK_4M);
        cb("cmode", 1'b0, cm_hi);
        wrap_up();
    end
endmodule

bind bps_sequencer bps_sequencer_props #(.BUS_FILTER_CYCLES(BUS_FILTER_CYCLES)) u_props (
    .MCLK(MCLK), .RST(RST), .BUS_ABOVE_CMP(BUS_ABOVE_CMP), .FILT_14V_CMP(FILT_14V_CMP),
    .FILT_12V_CMP(FILT_12V_CMP), .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN),
    .FIXED_BUCK_EN(FIXED_BUCK_EN), .ADJ_BUCK_EN(ADJ_BUCK_EN), .AUX_REG_EN(AUX_REG_EN),
    .OSC_EN(OSC_EN), .HOST_CLOCK_SEL(HOST_CLOCK_SEL), .SERIAL_ACTIVE(SERIAL_ACTIVE),
    .BUS_COMM_ACTIVE(BUS_COMM_ACTIVE), .EARLY_WARNING_N_O(EARLY_WARNING_N_O),
    .EARLY_WARNING_N_OE(EARLY_WARNING_N_OE), .HOST_RESET_N_O(HOST_RESET_N_O),
    .HOST_RESET_N_OE(HOST_RESET_N_OE), .POWER_STATE(POWER_STATE));
